//--- stim_ceiling.sv
// Combinational ceiling lookup for one divider and one drive setting.
// Assumes inputs are stable register values of the same clock.
`timescale 1ns/1ps
`include "stim_limit_params.svh"

module stim_ceiling (
   // Stimulus divider
   input  wire logic [11:0] divider,
   // Setting as {range, magnitude}
   input  wire logic [3:0]  setting,
   // Results
   output logic             over_limit,
   output logic [3:0]       max_setting,
   output logic [10:0]      setting_ua
);

   // ----------------------------------------
   // Decoders
   // ----------------------------------------
   // Current of a setting: quarter full scale times (magnitude + 1)
   function automatic logic [10:0] current_ua(input logic [3:0] s);
      logic [10:0] qfs;
      qfs = `RANGE0_QFS;
      case (s[3:2])
         2'h1: qfs = `RANGE1_QFS;
         2'h2: qfs = `RANGE2_QFS;
         2'h3: qfs = `RANGE3_QFS;
         default: qfs = `RANGE0_QFS;
      endcase
      current_ua = 11'(qfs * ({9'h000, s[1:0]} + 11'h001));
   endfunction

   wire logic [12:0] divp1 = {1'b0, divider} + 13'h0001;
   logic [10:0] limit_ua;

   // Higher frequency means smaller divider, so test from the top tier down
   always_comb begin
      if (divp1 <= `DIVP1_TIER4) begin
         limit_ua = `LIM4_UA;
         max_setting = `MAX4_SET;
      end else if (divp1 <= `DIVP1_TIER3) begin
         limit_ua = `LIM3_UA;
         max_setting = `MAX3_SET;
      end else if (divp1 <= `DIVP1_TIER2) begin
         limit_ua = `LIM2_UA;
         max_setting = `MAX2_SET;
      end else if (divp1 <= `DIVP1_TIER1) begin
         limit_ua = `LIM1_UA;
         max_setting = `MAX1_SET;
      end else begin
         limit_ua = `LIM0_UA;
         max_setting = `MAX0_SET;
      end
   end

   assign setting_ua = current_ua(setting);
   assign over_limit = setting_ua > limit_ua;

endmodule // stim_ceiling

//--- stim_current_guard.sv
// Register file of the stimulus transmitter with the current ceiling guard.
// Assumes a same-clock host port; read data stand one cycle after the strobe.
`timescale 1ns/1ps
`include "stim_limit_params.svh"

module stim_current_guard (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output logic      [7:0] rdata,
   // Drive settings to the transmitter
   output logic      [1:0] drive_magnitude_field,
   output logic      [1:0] drive_current_range_field,
   output logic     [11:0] stim_divider,
   output logic      [1:0] drive_mode,
   output logic            ext_ref_en,
   output logic            clamp_pulse
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [11:0]                   div_r, div_nxt;
   stim_limit_pkg::drive_cfg_type cfg_r, cfg_nxt;
   stim_limit_pkg::drive_mode_type mode_r;
   logic                          ext_r;
   logic [7:0]                    rdata_r, rdata_nxt;
   logic                          clamp_r;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire logic wr_lo   = wr_stb && (addr == `OFS_DIV_LO);
   wire logic wr_hi   = wr_stb && (addr == `OFS_DIV_HI);
   wire logic wr_cfg  = wr_stb && (addr == `OFS_DRIVE_CFG);
   wire logic wr_mode = wr_stb && (addr == `OFS_DRIVE_MODE);

   // Candidate values as they would stand after this write
   wire logic [11:0] div_cand = wr_lo ? {div_r[11:8], wdata}
                              : wr_hi ? {wdata[`DIV_HI_MSB:0], div_r[7:0]} : div_r;
   wire stim_limit_pkg::drive_cfg_type cfg_cand = wr_cfg ? stim_limit_pkg::drive_cfg_type'(wdata) : cfg_r;

   // Guard is armed only in current drive without the external reference
   wire logic guard_on = (mode_r == stim_limit_pkg::DRIVE_CURRENT) && !ext_r;
   wire logic guard_wr = wr_lo || wr_hi || wr_cfg;

   // ----------------------------------------
   // Ceiling on the candidate, and on the stored state for status
   // ----------------------------------------
   logic        cand_over;
   logic [3:0]  cand_max;
   logic        stored_over;
   logic [10:0] stored_ua;

   stim_ceiling u_cand (
      .divider     (div_cand),
      .setting     ({cfg_cand.drive_current_range_field, cfg_cand.drive_magnitude_field}),
      .over_limit  (cand_over),
      .max_setting (cand_max),
      .setting_ua  ()
   );

   stim_ceiling u_stored (
      .divider     (div_r),
      .setting     ({cfg_r.drive_current_range_field, cfg_r.drive_magnitude_field}),
      .over_limit  (stored_over),
      .max_setting (),
      .setting_ua  (stored_ua)
   );

   // Clamp within the same write so a readback already sees the limit
   wire logic do_clamp = guard_wr && guard_on && cand_over;

   always_comb begin
      div_nxt = div_cand;
      cfg_nxt = cfg_cand;
      if (do_clamp) begin
         cfg_nxt.drive_current_range_field = cand_max[3:2];
         cfg_nxt.drive_magnitude_field     = cand_max[1:0];
      end
   end

   // ----------------------------------------
   // Read mux: zero outside the cycle after a read strobe
   // ----------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_stb) begin
         case (addr)
            `OFS_DIV_LO:     rdata_nxt = div_r[7:0];
            `OFS_DIV_HI:     rdata_nxt = {4'h0, div_r[11:8]};
            `OFS_DRIVE_CFG:  rdata_nxt = cfg_r;
            `OFS_DRIVE_MODE: rdata_nxt = {5'h00, ext_r, mode_r};
            `OFS_STATUS:     rdata_nxt = {7'h00, guard_on && stored_over};
            default:         rdata_nxt = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_r   <= `RST_DIV;
         cfg_r   <= `RST_DRIVE_CFG;
         mode_r  <= stim_limit_pkg::drive_mode_type'(2'(`RST_DRIVE_MODE));
         ext_r   <= 1'(`RST_DRIVE_MODE >> `MODE_EXT_BIT);
         rdata_r <= 8'h00;
         clamp_r <= 1'b0;
      end else begin
         div_r   <= div_nxt;
         cfg_r   <= cfg_nxt;
         rdata_r <= rdata_nxt;
         clamp_r <= do_clamp;
         if (wr_mode) begin
            mode_r <= stim_limit_pkg::drive_mode_type'(wdata[1:0]);
            ext_r  <= wdata[`MODE_EXT_BIT];
         end
      end
   end

   // Outputs straight from flops
   assign rdata                     = rdata_r;
   assign drive_magnitude_field     = cfg_r.drive_magnitude_field;
   assign drive_current_range_field = cfg_r.drive_current_range_field;
   assign stim_divider              = div_r;
   assign drive_mode                = mode_r;
   assign ext_ref_en                = ext_r;
   assign clamp_pulse               = clamp_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_low_tier;
      @(posedge core_clk) disable iff (rst)
      (guard_wr && guard_on && ({1'b0, div_cand} + 13'h0001 > `DIVP1_TIER1)) |=> (stored_ua <= `LIM0_UA);
   endproperty
   a_low_tier: assert property (p_low_tier) else $error("Current above low-tier cap");

   property p_any_tier;
      @(posedge core_clk) disable iff (rst)
      (guard_wr && guard_on) |=> !stored_over;
   endproperty
   a_any_tier: assert property (p_any_tier) else $error("Setting left above ceiling");

   property p_override;
      @(posedge core_clk) disable iff (rst)
      do_clamp |=> ({drive_current_range_field, drive_magnitude_field} == $past(cand_max));
   endproperty
   a_override: assert property (p_override) else $error("Override not at maximum");

   property p_freq_trigger;
      @(posedge core_clk) disable iff (rst)
      ((wr_lo || wr_hi) && guard_on && cand_over) |=> clamp_pulse;
   endproperty
   a_freq_trigger: assert property (p_freq_trigger) else $error("Divider write missed clamp");

   property p_ext_ref;
      @(posedge core_clk) disable iff (rst)
      (wr_cfg && ext_r) |=> (cfg_r == $past(wdata)) && !clamp_pulse;
   endproperty
   a_ext_ref: assert property (p_ext_ref) else $error("Clamp under external reference");

   property p_no_limit_mode;
      @(posedge core_clk) disable iff (rst)
      (wr_cfg && (mode_r != stim_limit_pkg::DRIVE_CURRENT)) |=> (cfg_r == $past(wdata));
   endproperty
   a_no_limit_mode: assert property (p_no_limit_mode) else $error("Limit in voltage drive");

   property p_readback;
      @(posedge core_clk) disable iff (rst)
      (wr_cfg && guard_on && cand_over) ##1 (rd_stb && addr == `OFS_DRIVE_CFG) |=>
         (rdata[5:2] != $past(wdata[5:2], 2)) && ({rdata[3:2], rdata[5:4]} == $past(cand_max, 2));
   endproperty
   a_readback: assert property (p_readback) else $error("Readback not clamped");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (rst)
      !rd_stb |=> (rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside read slot");

   // Tier-by-tier ceilings after a guarded write; each tier checked on its own
   wire logic [12:0] cand_divp1 = {1'b0, div_cand} + 13'h0001;

   property p_tier1_cap;
      @(posedge core_clk) disable iff (rst)
      (guard_wr && guard_on && (cand_divp1 > `DIVP1_TIER2) && (cand_divp1 <= `DIVP1_TIER1))
         |=> (stored_ua <= `LIM1_UA);
   endproperty
   a_tier1_cap: assert property (p_tier1_cap) else $error("Current above second-tier cap");

   property p_tier2_cap;
      @(posedge core_clk) disable iff (rst)
      (guard_wr && guard_on && (cand_divp1 > `DIVP1_TIER3) && (cand_divp1 <= `DIVP1_TIER2))
         |=> (stored_ua <= `LIM2_UA);
   endproperty
   a_tier2_cap: assert property (p_tier2_cap) else $error("Current above third-tier cap");

   property p_tier3_cap;
      @(posedge core_clk) disable iff (rst)
      (guard_wr && guard_on && (cand_divp1 > `DIVP1_TIER4) && (cand_divp1 <= `DIVP1_TIER3))
         |=> (stored_ua <= `LIM3_UA);
   endproperty
   a_tier3_cap: assert property (p_tier3_cap) else $error("Current above fourth-tier cap");

   property p_tier4_cap;
      @(posedge core_clk) disable iff (rst)
      (guard_wr && guard_on && (cand_divp1 <= `DIVP1_TIER4)) |=> (stored_ua <= `LIM4_UA);
   endproperty
   a_tier4_cap: assert property (p_tier4_cap) else $error("Current above top-tier cap");

   // A setting that fits must be stored exactly as written
   property p_fit_kept;
      @(posedge core_clk) disable iff (rst)
      (guard_wr && !cand_over) |=> (cfg_r == $past(cfg_cand));
   endproperty
   a_fit_kept: assert property (p_fit_kept) else $error("Setting changed though within ceiling");

   // No clamp unless the guard is armed and a guarded field was written
   property p_clamp_armed;
      @(posedge core_clk) disable iff (rst)
      !(guard_wr && guard_on) |=> !clamp_pulse;
   endproperty
   a_clamp_armed: assert property (p_clamp_armed) else $error("Clamp without armed guard");

   // Readback of the drive byte shows the stored value
   property p_rdata_cfg;
      @(posedge core_clk) disable iff (rst)
      (rd_stb && (addr == `OFS_DRIVE_CFG)) |=> (rdata == $past(cfg_r));
   endproperty
   a_rdata_cfg: assert property (p_rdata_cfg) else $error("Drive byte readback differs");

endmodule // stim_current_guard

//--- stim_current_guard_test.sv
// Self-checking bench for the stimulus current ceiling guard.
// Assumes the register map and tier constants of the params header.
`timescale 1ns/1ps
`include "stim_limit_params.svh"

module stim_current_guard_test;
   // Clock, reset and register port
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic [7:0]  addr     = 8'h00;
   logic [7:0]  wdata    = 8'h00;
   logic        wr_stb   = 1'b0;
   logic        rd_stb   = 1'b0;
   // Observed outputs
   logic [7:0]  rdata;
   logic [1:0]  mag_o, rng_o, mode_o;
   logic [11:0] div_o;
   logic        ext_o, clamp_o;
   // Reference state and scoreboard
   logic [11:0] div_m;
   stim_limit_pkg::drive_cfg_type cfg_m;
   logic [1:0]  mode_m;
   logic        ext_m, pend_rd, pend_wr;
   logic [20:0] notes[$];
   logic [20:0] note;
   logic [14:0] tv;
   logic [31:0] seed = 32'h0000F7F4;
   int          bnd[4] = '{64, 128, 512, 2048};
   int          n_errors = 0;
   int          samples_checked = 0;

   stim_current_guard u_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .drive_magnitude_field(mag_o), .drive_current_range_field(rng_o),
      .stim_divider(div_o), .drive_mode(mode_o), .ext_ref_en(ext_o), .clamp_pulse(clamp_o));

   // 25 MHz clock
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Ceiling in uA and largest {range, magnitude} for a divider
   function automatic logic [14:0] tier(input logic [11:0] d);
      logic [12:0] p;
      p = {1'b0, d} + 13'h0001;
      if (p <= `DIVP1_TIER4) return {`LIM4_UA, `MAX4_SET};
      else if (p <= `DIVP1_TIER3) return {`LIM3_UA, `MAX3_SET};
      else if (p <= `DIVP1_TIER2) return {`LIM2_UA, `MAX2_SET};
      else if (p <= `DIVP1_TIER1) return {`LIM1_UA, `MAX1_SET};
      else return {`LIM0_UA, `MAX0_SET};
   endfunction

   // Stored setting above the ceiling while the guard is armed
   function automatic logic over();
      logic [10:0] q;
      logic [14:0] t;
      t = tier(div_m);
      case (cfg_m.drive_current_range_field)
         2'h0: q = `RANGE0_QFS;
         2'h1: q = `RANGE1_QFS;
         2'h2: q = `RANGE2_QFS;
         default: q = `RANGE3_QFS;
      endcase
      return (mode_m == 2'h0) && !ext_m && (q * ({9'h000, cfg_m.drive_magnitude_field} + 11'h001) > t[14:4]);
   endfunction

   // ----------------------------------------
   // Drivers; reads and writes note their expected result
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [14:0] t;
      logic        cl;
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      rd_stb <= 1'b0;
      case (a)
         `OFS_DIV_LO:     div_m[7:0] = d;
         `OFS_DIV_HI:     div_m[11:8] = d[3:0];
         `OFS_DRIVE_CFG:  cfg_m = d;
         `OFS_DRIVE_MODE: {ext_m, mode_m} = d[2:0];
         default: ;
      endcase
      t = tier(div_m);
      cl = (a >= `OFS_DIV_LO) && (a <= `OFS_DRIVE_CFG) && over();
      if (cl) {cfg_m.drive_current_range_field, cfg_m.drive_magnitude_field} = t[3:0];
      notes.push_back({1'b0, cl, cfg_m.drive_magnitude_field, cfg_m.drive_current_range_field, div_m, mode_m, ext_m});
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      logic [7:0] v;
      addr <= a;
      rd_stb <= 1'b1;
      wr_stb <= 1'b0;
      case (a)
         `OFS_DIV_LO:     v = div_m[7:0];
         `OFS_DIV_HI:     v = {4'h0, div_m[11:8]};
         `OFS_DRIVE_CFG:  v = cfg_m;
         `OFS_DRIVE_MODE: v = {5'h00, ext_m, mode_m};
         `OFS_STATUS:     v = {7'h00, over()};
         default:         v = 8'h00;
      endcase
      notes.push_back({1'b1, 12'h000, v});
      @(posedge core_clk);
   endtask

   task automatic idle();
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      div_m = `RST_DIV;
      cfg_m = `RST_DRIVE_CFG;
      {ext_m, mode_m} = `RST_DRIVE_MODE;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
   endtask

   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Results stand one cycle after their strobe; idle rdata and clamp_pulse stay at zero
   initial begin
      pend_rd = 1'b0;
      pend_wr = 1'b0;
      forever begin
         @(negedge core_clk);
         if (pend_rd || pend_wr) note = notes.pop_front();
         if (pend_rd) check("rdata", {12'h000, rdata}, note[19:0]);
         else check("idle rdata", {12'h000, rdata}, 20'h00000);
         if (pend_wr) check("drive", {clamp_o, mag_o, rng_o, div_o, mode_o, ext_o}, note[19:0]);
         else check("idle clamp", {19'h00000, clamp_o}, 20'h00000);
         pend_rd = rd_stb;
         pend_wr = wr_stb;
      end
   end

   // Watchdog well beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      give_verdict();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      do_reset();
      for (int a = 32; a <= 39; a++) rd(8'(a));
      rd(8'hFF);
      wr(`OFS_DRIVE_CFG, 8'h3C);
      rd(`OFS_DRIVE_CFG);
      // Frequency first, then magnitude, then slow down again
      wr(`OFS_DIV_LO, 8'h3F);
      wr(`OFS_DIV_HI, 8'h00);
      wr(`OFS_DRIVE_CFG, 8'hFC);
      wr(`OFS_DIV_HI, 8'h0F);
      rd(`OFS_STATUS);
      // Tier edges: exact limit setting, then full scale
      foreach (bnd[i]) for (int k = 0; k < 2; k++) begin
         wr(`OFS_DIV_LO, 8'(bnd[i] - 1 + k));
         wr(`OFS_DIV_HI, 8'((bnd[i] - 1 + k) >> 8));
         tv = tier(div_m);
         wr(`OFS_DRIVE_CFG, {2'h0, tv[1:0], tv[3:2], 2'h3});
         wr(`OFS_DRIVE_CFG, 8'hFC);
      end
      // Every mode and reference choice; mode change alone does not re-check
      for (int m = 0; m < 8; m++) begin
         wr(`OFS_DRIVE_MODE, 8'(m));
         wr(`OFS_DRIVE_CFG, 8'hFC);
      end
      wr(`OFS_DRIVE_MODE, 8'h00);
      rd(`OFS_STATUS);
      // Random back-to-back traffic over the map and three unmapped places
      repeat (300) begin
         seed = xs(seed);
         if (seed[0]) rd(8'h20 + {5'h00, seed[3:1]});
         else wr(8'h20 + {5'h00, seed[3:1]}, seed[15:8]);
      end
      idle();
      idle();
      do_reset();
      for (int a = 32; a <= 36; a++) rd(8'(a));
      idle();
      idle();
      give_verdict();
   end
endmodule // stim_current_guard_test

//--- stim_limit_params.svh
// Constants for the stimulus current ceiling guard.
// Assumes one 25 MHz register clock and an 8-bit register port.
`ifndef STIM_LIMIT_PARAMS_SVH
`define STIM_LIMIT_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_DIV_LO      8'h20
`define OFS_DIV_HI      8'h21
`define OFS_DRIVE_CFG   8'h22
`define OFS_DRIVE_MODE  8'h23
`define OFS_STATUS      8'h24

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DIV         12'hFFF
`define RST_DRIVE_CFG   8'h00
`define RST_DRIVE_MODE  3'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DIV_HI_MSB      3
`define MODE_EXT_BIT    2

// ----------------------------------------
// Frequency tiers: stimulus_frequency = REF / (divider + 1)
// ----------------------------------------
`define STIM_REF_HZ     1048576
`define TIER1_HZ        512
`define TIER2_HZ        2048
`define TIER3_HZ        8192
`define TIER4_HZ        16384
`define DIVP1_TIER1     13'(`STIM_REF_HZ / `TIER1_HZ)
`define DIVP1_TIER2     13'(`STIM_REF_HZ / `TIER2_HZ)
`define DIVP1_TIER3     13'(`STIM_REF_HZ / `TIER3_HZ)
`define DIVP1_TIER4     13'(`STIM_REF_HZ / `TIER4_HZ)

// ----------------------------------------
// Current ceilings in uA and the largest setting in each tier
// ----------------------------------------
`define LIM0_UA         11'd64
`define LIM1_UA         11'd128
`define LIM2_UA         11'd256
`define LIM3_UA         11'd640
`define LIM4_UA         11'd1280
`define MAX0_SET        4'h5
`define MAX1_SET        4'h7
`define MAX2_SET        4'h9
`define MAX3_SET        4'hD
`define MAX4_SET        4'hF

// Quarter full scale per range, in uA
`define RANGE0_QFS      11'd8
`define RANGE1_QFS      11'd32
`define RANGE2_QFS      11'd128
`define RANGE3_QFS      11'd320

`endif

//--- stim_limit_pkg.sv
// Types for the stimulus current ceiling guard.
// Assumes the params header supplies every number.
package stim_limit_pkg;

   // ----------------------------------------
   // Drive configuration byte
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] upper;
      logic [1:0] drive_magnitude_field;
      logic [1:0] drive_current_range_field;
      logic [1:0] lower;
   } drive_cfg_type;

   // ----------------------------------------
   // Transmit drive mode
   // ----------------------------------------
   typedef enum logic [1:0] {
      DRIVE_CURRENT,
      DRIVE_VOLTAGE,
      DRIVE_HBRIDGE,
      DRIVE_SPARE
   } drive_mode_type;

endpackage
